// file: bench/cix_exec_chk.sv
// Port-level checker for the execution unit
`default_nettype none
module cix_exec_chk
  import cix_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_reset,
  input wire logic        i_issue,
  input wire cix_op_t     i_op,
  input wire logic        i_reg_we,
  input wire logic        o_ready,
  input wire cix_flags_t  o_flags,
  input wire logic        o_inhibit,
  input wire logic        o_mem_we,
  input wire logic        o_mem_re,
  input wire logic        o_io_in_ack,
  input wire logic        o_io_out_ack,
  input wire logic [15:0] o_io_data
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  a_issue_taken: assert property (i_issue && o_ready |=> !o_ready)
    else $error("ready held after issue");
  a_in_ack_pulse: assert property (o_io_in_ack |=> !o_io_in_ack)
    else $error("input ack too long");
  a_out_ack_pulse: assert property (o_io_out_ack |=> !o_io_out_ack)
    else $error("output ack too long");
  a_mem_excl: assert property (!(o_mem_we && o_mem_re))
    else $error("read and write together");
  a_lockout_kept: assert property (!i_reg_we |=> $stable(o_flags.lockout))
    else $error("lockout changed");
  a_data_justified: assert property (o_io_data[15] == 1'b0)
    else $error("trunk bit 15 set");
  a_branch_inhibit: assert property (i_issue && o_ready
    && (i_op inside {[OP_UNCONDITIONAL_BRANCH:OP_BRANCH_IF_ZERO]})
    |-> ##[1:3] o_inhibit)
    else $error("branch did not inhibit");
  a_clear_flags: assert property (i_issue && o_ready
    && i_op == OP_CLEAR_MEMORY_WORD
    |-> ##[1:3] (o_flags.zero && o_flags.positive))
    else $error("clear did not set flags");
endmodule : cix_exec_chk
bind cix_exec cix_exec_chk u_chk (.*);
`default_nettype wire

// file: bench/cix_mem_model.sv
// Behavioural core memory behind the execution unit
`default_nettype none
module cix_mem_model (
  input  wire logic        i_clk,
  input  wire logic [15:0] i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_we,
  input  wire logic        i_re,
  output logic      [15:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] m [0:511];
  // Read data follows the registered address in the strobe cycle; idle bus shows inverted data
  assign o_rdata = i_re ? m[i_addr[8:0]] : ~m[i_addr[8:0]];
  // Vector words share the flat space
  always @(posedge i_clk) begin
    if (i_we) m[i_addr[8:0]] <= i_wdata;
  end
endmodule : cix_mem_model
`default_nettype wire

// file: bench/tb_cix_exec.sv
// Self-checking bench for the execution unit
`default_nettype none
module tb_cix_exec
  import cix_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_reset = 1, i_issue = 0, i_ext_irq = 0, i_reg_we = 0, i_reg_re = 0;
  logic i_sri_req = 1'b0;
  logic [5:0] i_sri_num = 6'h00;
  cix_op_t i_op = OP_NOP;
  logic [15:0] i_opd_addr = 0, i_reg_wdata = 0, i_io_data = 16'hc321;
  logic [1:0] i_reg_addr = 0;
  logic [15:0] ma, mw, mr, o_pc, o_io_data, o_reg_rdata;
  logic mwe, mre, o_ready, o_inhibit;
  cix_flags_t o_flags;
  cix_chan_addr_t o_io_addr;
  int err_count, checks_done;
  cix_exec DUT (.i_clk(i_clk), .i_reset(i_reset), .i_issue(i_issue), .i_op(i_op),
    .i_opd_addr(i_opd_addr), .o_ready(o_ready), .o_pc(o_pc), .o_flags(o_flags),
    .o_inhibit(o_inhibit), .o_mem_addr(ma), .o_mem_wdata(mw), .o_mem_we(mwe),
    .o_mem_re(mre), .i_mem_rdata(mr), .i_io_data(i_io_data), .o_io_data(o_io_data),
    .o_io_addr(o_io_addr), .o_io_addr_stb(), .o_io_in_ack(), .o_io_out_ack(),
    .i_ext_irq(i_ext_irq), .i_sri_req(i_sri_req), .i_sri_num(i_sri_num), .o_sri_exhaust(),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_we(i_reg_we),
    .i_reg_re(i_reg_re), .o_reg_rdata(o_reg_rdata));
  cix_mem_model u_mem (.i_clk(i_clk), .i_addr(ma), .i_wdata(mw), .i_we(mwe), .i_re(mre),
    .o_rdata(mr));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_we <= 1'b1;
    @(posedge i_clk);
    i_reg_we <= 1'b0;
  endtask : wr
  task automatic rdchk(input logic [1:0] a, input logic [15:0] exp);
    @(posedge i_clk);
    i_reg_addr <= a;
    i_reg_re <= 1'b1;
    @(posedge i_clk);
    i_reg_re <= 1'b0;
    #1 chk(o_reg_rdata, exp);
  endtask : rdchk
  // Issue is held until it meets ready at an edge, then the unit is waited for
  task automatic ex(input cix_op_t op, input logic [15:0] a);
    @(posedge i_clk);
    i_op <= op;
    i_opd_addr <= a;
    i_issue <= 1'b1;
    do @(posedge i_clk); while (o_ready !== 1'b1);
    i_issue <= 1'b0;
    do @(posedge i_clk); while (o_ready !== 1'b1);
    #1;
  endtask : ex
  task automatic test_done;
    if (err_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  initial begin
    #100000 err_count++;
    test_done();
  end
  initial begin
    repeat (8) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk) #1;
    u_mem.m[9'h020] = 16'h7fff;
    u_mem.m[9'h021] = 16'h0000;
    u_mem.m[9'h023] = 16'h8001;
    u_mem.m[9'h024] = 16'h1234;
    u_mem.m[9'h025] = 16'h5678;
    u_mem.m[9'h027] = 16'h0abc;
    u_mem.m[9'h030] = 16'hffff;
    u_mem.m[9'h100] = 16'h6830;
    u_mem.m[9'h102] = 16'h6841;
    u_mem.m[9'h041] = 16'hffff;
    u_mem.m[9'h10c] = 16'h5880;
    u_mem.m[9'h10d] = 16'hffff;
    u_mem.m[9'h180] = 16'h0040;
    u_mem.m[9'h040] = 16'h0155;
    wr(REG_FLAGS, 16'h0010);
    ex(OP_ADD_ONE_TO_MEMORY, 16'h0020);
    chk(u_mem.m[9'h020], 16'h8000);
    rdchk(REG_FLAGS, 16'h0018);
    ex(OP_SUBTRACT_ONE_FROM_MEMORY, 16'h0021);
    chk(u_mem.m[9'h021], 16'hffff);
    rdchk(REG_FLAGS, 16'h0018);
    ex(OP_CLEAR_MEMORY_WORD, 16'h0021);
    rdchk(REG_FLAGS, 16'h001b);
    wr(REG_FLAGS, 16'h0000);
    wr(REG_SHDESC, 16'h0021);
    ex(OP_MEMORY_SHIFT, 16'h0023);
    chk(u_mem.m[9'h023], 16'h0003);
    rdchk(REG_FLAGS, 16'h000e);
    wr(REG_SHDESC, 16'h0184);
    ex(OP_MEMORY_SHIFT, 16'h0024);
    chk(u_mem.m[9'h024], 16'h0123);
    chk(u_mem.m[9'h025], 16'h4567);
    rdchk(REG_SHDESC, 16'h0184);
    for (int k = 0; k < 10; k++) begin
      wr(REG_FLAGS, k > 4 ? 16'h001f : 16'h0000);
      wr(REG_PC, 16'h0050);
      ex(cix_op_t'(OP_BRANCH_IF_POSITIVE + k % 5), 16'h0077);
      chk(o_pc, ((k > 4) ^ (k % 5 == 3)) ? 16'h0077 : 16'h0051);
    end
    ex(OP_UNCONDITIONAL_BRANCH, 16'h0123);
    chk(o_pc, 16'h0123);
    wr(REG_ACC, 16'h1234);
    ex(OP_ACCUMULATOR_CHANNEL_TRANSFER, 16'h0d09);
    chk(o_io_addr, 16'h0d09);
    chk(o_io_data, 16'h1234);
    rdchk(REG_FLAGS, 16'h001e);
    ex(OP_ACCUMULATOR_CHANNEL_TRANSFER, 16'h0089);
    rdchk(REG_ACC, 16'h4321);
    ex(OP_MEMORY_FROM_INPUT_TRUNK, 16'h0026);
    chk(u_mem.m[9'h026], 16'h4321);
    ex(OP_MEMORY_TO_OUTPUT_TRUNK, 16'h0027);
    chk(o_io_data, 16'h0abc);
    @(posedge i_clk);
    i_ext_irq <= 1'b1;
    for (int n = 0; n < 60 && u_mem.m[9'h030] !== 16'h0000; n++) @(posedge i_clk);
    chk(u_mem.m[9'h030], 16'h0000);
    i_sri_num <= 6'h06;
    i_sri_req <= 1'b1;
    for (int n = 0; n < 80 && u_mem.m[9'h041] !== 16'h0000; n++) @(posedge i_clk);
    chk(u_mem.m[9'h10d], 16'h0000);
    chk(o_io_data, 16'h0155);
    chk(u_mem.m[9'h041], 16'h0000);
    test_done();
  end
endmodule : tb_cix_exec
`default_nettype wire

// file: rtl/cix_exec.sv
// Instruction execution unit with direct and buffered channel completion handling
// Operation
// - Increment adds one to memory in place; sets zero, positive, carry; overflow sticky.
// - Decrement subtracts one from memory in place; same designator effects as increment.
// - Memory shift per descriptor; zero, positive from result; carry is last bit out.
// - Left shift sets overflow when the sign bit changes; lockout never touched.
// - Left/right, circular or open with sign/zero fill, single/double, up to 31.
// - Double shift: addressed word most significant, next address least significant.
// - Unconditional branch loads PC, keeps designators, blocks external interrupt once.
// - Conditional branches on positive, overflow, carry, negative, zero; same side effects.
// - Input transfer writes trunk data to memory and pulses input acknowledge.
// - Output transfer puts memory word on trunk and pulses output acknowledge.
// - Channel transfer sends address; bit 7 set loads accumulator from trunk.
// - Bit 7 clear drives accumulator to trunk; zero, positive from output value.
// - Channel address: number bits 6-0, direction bit 7, multiplexer word 13-8.
// - Channel data is right justified ending at bit 14.
// - Clear word writes zero, sets zero and positive, keeps the rest.
// - External interrupt executes the word at hex 100 out of sequence, then resumes.
// - Up to 63 service requests, four reserved, 59 general.
// - Request N owns hex 100+2N transfer word and hex 101+2N negative count.
// - Buffered request runs stored transfer with designators frozen, indexed by count.
// - Program keeps running; channel completion only reacts through interrupts.
// - Buffered transfer pointer is hex 100 plus displacement.
// - Count reaching zero raises service request 1.
`default_nettype none

module cix_exec
  import cix_pkg::*;
(
  input  wire logic           i_clk,
  input  wire logic           i_reset,
  input  wire logic           i_issue,
  input  wire cix_op_t        i_op,
  input  wire logic [15:0]    i_opd_addr,
  output logic                o_ready,
  output logic [15:0]         o_pc,
  output cix_flags_t          o_flags,
  output logic                o_inhibit,
  output logic [15:0]         o_mem_addr,
  output logic [15:0]         o_mem_wdata,
  output logic                o_mem_we,
  output logic                o_mem_re,
  input  wire logic [15:0]    i_mem_rdata,
  input  wire logic [15:0]    i_io_data,
  output logic [15:0]         o_io_data,
  output cix_chan_addr_t      o_io_addr,
  output logic                o_io_addr_stb,
  output logic                o_io_in_ack,
  output logic                o_io_out_ack,
  input  wire logic           i_ext_irq,
  input  wire logic           i_sri_req,
  input  wire logic [5:0]     i_sri_num,
  output logic                o_sri_exhaust,
  input  wire logic [1:0]     i_reg_addr,
  input  wire logic [15:0]    i_reg_wdata,
  input  wire logic           i_reg_we,
  input  wire logic           i_reg_re,
  output logic [15:0]         o_reg_rdata
);

  typedef enum {
    ST_IDLE, ST_FETCH, ST_FDEC, ST_START, ST_CNT, ST_RD0, ST_RD1, ST_RD2, ST_EXEC, ST_WR1
  } cix_state_t;

  cix_state_t  state_q;
  cix_op_t     op_q;
  cix_pin_in_t sync1_q;
  cix_pin_in_t sync2_q;
  logic        ext_prev_q;
  logic        sri_prev_q;
  logic        ext_pend_q;
  logic        x1_pend_q;
  logic        sri_pend_q;
  logic [5:0]  sri_num_q;
  logic [5:0]  vec_q;
  logic        oos_q;
  logic        buf_q;
  logic [15:0] addr_q;
  logic [15:0] hi_q;
  logic [15:0] lo_q;
  logic [15:0] start_q;
  logic [15:0] acc_q;
  logic [15:0] desc_q;

  logic [15:0] sh_hi;
  logic [15:0] sh_lo;
  logic        sh_c;
  logic        sh_cv;
  logic        sh_ovf;
  logic [16:0] inc_sum;
  logic [16:0] dec_sum;
  logic [15:0] cnt_inc;
  logic [15:0] io_in;
  logic [15:0] acc_out;
  logic        shift_dbl;
  logic        accept;
  logic        take_ext;
  logic        take_x1;
  logic        take_sri;
  logic        is_branch;
  logic        branch_go;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {i_ext_irq, i_sri_req, i_sri_num, i_io_data};
      sync2_q <= sync1_q;
    end
  end

  // ---------------------------------------------------------------
  // Datapath helpers
  // ---------------------------------------------------------------
  cix_shifter u_shifter (
    .i_hi          (hi_q),
    .i_lo          (lo_q),
    .i_desc        (desc_q),
    .o_hi          (sh_hi),
    .o_lo          (sh_lo),
    .o_carry       (sh_c),
    .o_carry_valid (sh_cv),
    .o_ovf         (sh_ovf)
  );

  assign inc_sum   = {1'b0, hi_q} + 17'h00001;
  assign dec_sum   = {1'b0, hi_q} + 17'h0ffff;
  assign cnt_inc   = i_mem_rdata + 16'h0001;
  assign io_in     = sync2_q.io_data & CHAN_DATA_MASK;
  assign acc_out   = acc_q & CHAN_DATA_MASK;
  assign shift_dbl = (op_q == OP_MEMORY_SHIFT) && desc_q[SD_DBL];
  assign accept    = (state_q == ST_IDLE) && i_issue && o_ready;

  // Ready is low for the first idle cycle so pending interrupts win a slot
  assign take_ext  = (state_q == ST_IDLE) && !accept && ext_pend_q && !o_inhibit;
  assign take_x1   = (state_q == ST_IDLE) && !accept && !take_ext && x1_pend_q;
  assign take_sri  = (state_q == ST_IDLE) && !accept && !take_ext && !x1_pend_q && sri_pend_q;

  always_comb begin
    is_branch = 1'b1;
    branch_go = 1'b0;
    case (op_q)
      OP_UNCONDITIONAL_BRANCH: branch_go = 1'b1;
      OP_BRANCH_IF_POSITIVE:   branch_go = o_flags.positive;
      OP_BRANCH_IF_OVERFLOW:   branch_go = o_flags.overflow;
      OP_BRANCH_IF_CARRY:      branch_go = o_flags.carry;
      OP_BRANCH_IF_NEGATIVE:   branch_go = ~o_flags.positive;
      OP_BRANCH_IF_ZERO:       branch_go = o_flags.zero;
      default:                 is_branch = 1'b0;
    endcase
  end

  function automatic cix_state_t first_state(input cix_op_t op);
    case (op)
      OP_ADD_ONE_TO_MEMORY,
      OP_SUBTRACT_ONE_FROM_MEMORY,
      OP_MEMORY_SHIFT,
      OP_MEMORY_TO_OUTPUT_TRUNK: first_state = ST_RD0;
      default:                   first_state = ST_EXEC;
    endcase
  endfunction : first_state

  // ---------------------------------------------------------------
  // Interrupt pending latches
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ext_prev_q <= 1'b0;
      sri_prev_q <= 1'b0;
      ext_pend_q <= 1'b0;
      x1_pend_q  <= 1'b0;
      sri_pend_q <= 1'b0;
      sri_num_q  <= 6'h00;
    end else begin
      ext_prev_q <= sync2_q.ext_irq;
      sri_prev_q <= sync2_q.sri_req;
      // New events win over the clear of a request being taken
      if (sync2_q.ext_irq && !ext_prev_q) begin
        ext_pend_q <= 1'b1;
      end else if (take_ext) begin
        ext_pend_q <= 1'b0;
      end
      if (state_q == ST_CNT && buf_q && cnt_inc == 16'h0000) begin
        x1_pend_q <= 1'b1;
      end else if (take_x1) begin
        x1_pend_q <= 1'b0;
      end
      if (sync2_q.sri_req && !sri_prev_q && sync2_q.sri_num != 6'h00) begin
        sri_pend_q <= 1'b1;
        sri_num_q  <= sync2_q.sri_num;
      end else if (take_sri) begin
        sri_pend_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Sequencer and memory / channel port
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_q       <= ST_IDLE;
      o_ready       <= 1'b0;
      op_q          <= OP_NOP;
      addr_q        <= 16'h0000;
      hi_q          <= 16'h0000;
      lo_q          <= 16'h0000;
      start_q       <= 16'h0000;
      vec_q         <= 6'h00;
      oos_q         <= 1'b0;
      buf_q         <= 1'b0;
      o_mem_addr    <= 16'h0000;
      o_mem_wdata   <= 16'h0000;
      o_mem_we      <= 1'b0;
      o_mem_re      <= 1'b0;
      o_io_data     <= 16'h0000;
      o_io_addr     <= '0;
      o_io_addr_stb <= 1'b0;
      o_io_in_ack   <= 1'b0;
      o_io_out_ack  <= 1'b0;
      o_sri_exhaust <= 1'b0;
    end else begin
      o_mem_we      <= 1'b0;
      o_mem_re      <= 1'b0;
      o_io_addr_stb <= 1'b0;
      o_io_in_ack   <= 1'b0;
      o_io_out_ack  <= 1'b0;
      o_sri_exhaust <= 1'b0;
      o_ready       <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (accept) begin
            op_q    <= i_op;
            addr_q  <= i_opd_addr;
            oos_q   <= 1'b0;
            buf_q   <= 1'b0;
            state_q <= first_state(i_op);
          end else if (take_ext || take_x1 || take_sri) begin
            oos_q   <= 1'b1;
            vec_q   <= take_ext ? 6'h00 : (take_x1 ? SRI_EXHAUST : sri_num_q);
            buf_q   <= take_sri && (sri_num_q >= SRI_FIRST_GEN);
            state_q <= ST_FETCH;
          end else begin
            o_ready <= 1'b1;
          end
        end
        ST_FETCH: begin
          o_mem_re   <= 1'b1;
          o_mem_addr <= vec_addr(vec_q);
          state_q    <= ST_FDEC;
        end
        ST_FDEC: begin
          op_q <= cix_op_t'(i_mem_rdata[15:11]);
          if (buf_q) begin
            o_mem_re   <= 1'b1;
            o_mem_addr <= PTR_BASE + {8'h00, i_mem_rdata[7:0]};
            state_q    <= ST_START;
          end else begin
            addr_q  <= {8'h00, i_mem_rdata[7:0]};
            state_q <= first_state(cix_op_t'(i_mem_rdata[15:11]));
          end
        end
        ST_START: begin
          start_q    <= i_mem_rdata;
          o_mem_re   <= 1'b1;
          o_mem_addr <= vec_addr(vec_q) + VEC_LEN_OFS;
          state_q    <= ST_CNT;
        end
        ST_CNT: begin
          o_mem_we      <= 1'b1;
          o_mem_wdata   <= cnt_inc;
          addr_q        <= start_q + cnt_inc;
          o_sri_exhaust <= (cnt_inc == 16'h0000);
          state_q       <= first_state(op_q);
        end
        ST_RD0: begin
          o_mem_re   <= 1'b1;
          o_mem_addr <= addr_q;
          state_q    <= ST_RD1;
        end
        ST_RD1: begin
          hi_q <= i_mem_rdata;
          if (shift_dbl) begin
            o_mem_re   <= 1'b1;
            o_mem_addr <= addr_q + 16'h0001;
            state_q    <= ST_RD2;
          end else begin
            state_q <= ST_EXEC;
          end
        end
        ST_RD2: begin
          lo_q    <= i_mem_rdata;
          state_q <= ST_EXEC;
        end
        ST_EXEC: begin
          o_mem_addr <= addr_q;
          state_q    <= shift_dbl ? ST_WR1 : ST_IDLE;
          case (op_q)
            OP_ADD_ONE_TO_MEMORY: begin
              o_mem_we    <= 1'b1;
              o_mem_wdata <= inc_sum[15:0];
            end
            OP_SUBTRACT_ONE_FROM_MEMORY: begin
              o_mem_we    <= 1'b1;
              o_mem_wdata <= dec_sum[15:0];
            end
            OP_MEMORY_SHIFT: begin
              o_mem_we    <= 1'b1;
              o_mem_wdata <= sh_hi;
            end
            OP_CLEAR_MEMORY_WORD: begin
              o_mem_we    <= 1'b1;
              o_mem_wdata <= 16'h0000;
            end
            OP_MEMORY_FROM_INPUT_TRUNK: begin
              o_mem_we    <= 1'b1;
              o_mem_wdata <= io_in;
              o_io_in_ack <= 1'b1;
            end
            OP_MEMORY_TO_OUTPUT_TRUNK: begin
              o_io_data    <= hi_q & CHAN_DATA_MASK;
              o_io_out_ack <= 1'b1;
            end
            OP_ACCUMULATOR_CHANNEL_TRANSFER: begin
              o_io_addr     <= cix_chan_addr_t'(addr_q);
              o_io_addr_stb <= 1'b1;
              if (!addr_q[CHAN_DIR_BIT]) begin
                o_io_data <= acc_out;
              end
            end
            default: begin
            end
          endcase
        end
        ST_WR1: begin
          o_mem_we    <= 1'b1;
          o_mem_addr  <= addr_q + 16'h0001;
          o_mem_wdata <= sh_lo;
          state_q     <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Designators
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_flags <= '0;
    end else begin
      if (i_reg_we && i_reg_addr == REG_FLAGS) begin
        o_flags <= cix_flags_t'(i_reg_wdata[4:0]);
      end
      // Buffered executions leave every designator alone
      if (state_q == ST_EXEC && !buf_q) begin
        case (op_q)
          OP_ADD_ONE_TO_MEMORY: begin
            o_flags          <= set_zp(o_flags, inc_sum[15:0]);
            o_flags.carry    <= inc_sum[16];
            o_flags.overflow <= o_flags.overflow | (~hi_q[15] & inc_sum[15]);
          end
          OP_SUBTRACT_ONE_FROM_MEMORY: begin
            o_flags          <= set_zp(o_flags, dec_sum[15:0]);
            o_flags.carry    <= dec_sum[16];
            o_flags.overflow <= o_flags.overflow | (hi_q[15] & ~dec_sum[15]);
          end
          OP_MEMORY_SHIFT: begin
            o_flags          <= set_zp(o_flags, (shift_dbl && sh_hi == 16'h0000) ? sh_lo : sh_hi);
            o_flags.positive <= ~sh_hi[15];
            o_flags.carry    <= sh_cv ? sh_c : o_flags.carry;
            o_flags.overflow <= o_flags.overflow | sh_ovf;
          end
          OP_CLEAR_MEMORY_WORD: begin
            o_flags.zero     <= 1'b1;
            o_flags.positive <= 1'b1;
          end
          OP_ACCUMULATOR_CHANNEL_TRANSFER: begin
            o_flags <= set_zp(o_flags, addr_q[CHAN_DIR_BIT] ? io_in : acc_out);
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Accumulator, shift descriptor, program counter, inhibit
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      acc_q     <= ACC_RST;
      desc_q    <= SHDESC_RST;
      o_pc      <= PC_RST;
      o_inhibit <= 1'b0;
    end else begin
      if (i_reg_we && i_reg_addr == REG_ACC) begin
        acc_q <= i_reg_wdata;
      end
      if (i_reg_we && i_reg_addr == REG_SHDESC) begin
        desc_q <= i_reg_wdata;
      end
      if (i_reg_we && i_reg_addr == REG_PC) begin
        o_pc <= i_reg_wdata;
      end
      if (state_q == ST_EXEC) begin
        if (op_q == OP_ACCUMULATOR_CHANNEL_TRANSFER && addr_q[CHAN_DIR_BIT]) begin
          acc_q <= io_in;
        end
        if (branch_go) begin
          o_pc <= addr_q;
        end else if (!oos_q) begin
          o_pc <= o_pc + 16'h0001;
        end
        if (!oos_q) begin
          o_inhibit <= is_branch;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Register read port
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_reg_rdata <= 16'h0000;
    end else if (i_reg_re) begin
      case (i_reg_addr)
        REG_ACC:    o_reg_rdata <= acc_q;
        REG_SHDESC: o_reg_rdata <= desc_q;
        REG_FLAGS:  o_reg_rdata <= {10'h000, (state_q != ST_IDLE), o_flags};
        REG_PC:     o_reg_rdata <= o_pc;
        default:    o_reg_rdata <= 16'h0000;
      endcase
    end else begin
      o_reg_rdata <= 16'h0000;
    end
  end

endmodule : cix_exec

`default_nettype wire

// file: rtl/cix_pkg.sv
// Shared constants and types for the instruction execution and I/O channel block
`default_nettype none

package cix_pkg;

  // ---------------------------------------------------------------
  // Memory map of the interrupt vectors
  // ---------------------------------------------------------------
  localparam logic [15:0] EXT_VECTOR    = 16'h0100;
  localparam logic [15:0] VEC_LEN_OFS   = 16'h0001;
  localparam logic [15:0] PTR_BASE      = 16'h0100;
  localparam logic [5:0]  SRI_EXHAUST   = 6'h01;
  localparam logic [5:0]  SRI_FIRST_GEN = 6'h05;
  localparam logic [5:0]  SRI_MAX       = 6'h3f;

  // ---------------------------------------------------------------
  // Channel word layout
  // ---------------------------------------------------------------
  localparam logic [15:0] CHAN_DATA_MASK = 16'h7fff;
  localparam int          CHAN_DIR_BIT   = 7;

  // ---------------------------------------------------------------
  // Shift descriptor fields
  // ---------------------------------------------------------------
  localparam int         SD_CNT_LSB  = 0;
  localparam int         SD_LEFT     = 5;
  localparam int         SD_TYPE_LSB = 6;
  localparam int         SD_DBL      = 8;
  localparam logic [1:0] SH_CIRC     = 2'h0;
  localparam logic [1:0] SH_SIGN     = 2'h1;
  localparam logic [1:0] SH_ZERO     = 2'h2;

  // ---------------------------------------------------------------
  // Register offsets and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0]  REG_ACC    = 2'h0;
  localparam logic [1:0]  REG_SHDESC = 2'h1;
  localparam logic [1:0]  REG_FLAGS  = 2'h2;
  localparam logic [1:0]  REG_PC     = 2'h3;
  localparam logic [15:0] ACC_RST    = 16'h0000;
  localparam logic [15:0] SHDESC_RST = 16'h0000;
  localparam logic [15:0] PC_RST     = 16'h0000;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_NOP                          = 5'h00,
    OP_ADD_ONE_TO_MEMORY            = 5'h01,
    OP_SUBTRACT_ONE_FROM_MEMORY     = 5'h02,
    OP_MEMORY_SHIFT                 = 5'h03,
    OP_UNCONDITIONAL_BRANCH         = 5'h04,
    OP_BRANCH_IF_POSITIVE           = 5'h05,
    OP_BRANCH_IF_OVERFLOW           = 5'h06,
    OP_BRANCH_IF_CARRY              = 5'h07,
    OP_BRANCH_IF_NEGATIVE           = 5'h08,
    OP_BRANCH_IF_ZERO               = 5'h09,
    OP_MEMORY_FROM_INPUT_TRUNK      = 5'h0a,
    OP_MEMORY_TO_OUTPUT_TRUNK       = 5'h0b,
    OP_ACCUMULATOR_CHANNEL_TRANSFER = 5'h0c,
    OP_CLEAR_MEMORY_WORD            = 5'h0d
  } cix_op_t;

  typedef struct packed {
    logic lockout;
    logic overflow;
    logic carry;
    logic positive;
    logic zero;
  } cix_flags_t;

  typedef struct packed {
    logic [1:0] spare;
    logic [5:0] mux_word;
    logic       dir_in;
    logic [6:0] chan;
  } cix_chan_addr_t;

  typedef struct packed {
    logic        ext_irq;
    logic        sri_req;
    logic [5:0]  sri_num;
    logic [15:0] io_data;
  } cix_pin_in_t;

  function automatic logic [15:0] vec_addr(input logic [5:0] n);
    vec_addr = EXT_VECTOR + {9'h000, n, 1'b0};
  endfunction : vec_addr

  function automatic cix_flags_t set_zp(input cix_flags_t f, input logic [15:0] v);
    set_zp          = f;
    set_zp.zero     = (v == 16'h0000);
    set_zp.positive = ~v[15];
  endfunction : set_zp

endpackage : cix_pkg

`default_nettype wire

// file: rtl/cix_shifter.sv
// Combinational single/double word shifter steered by the shift descriptor
`default_nettype none

module cix_shifter
  import cix_pkg::*;
(
  input  wire logic [15:0] i_hi,
  input  wire logic [15:0] i_lo,
  input  wire logic [15:0] i_desc,
  output logic      [15:0] o_hi,
  output logic      [15:0] o_lo,
  output logic             o_carry,
  output logic             o_carry_valid,
  output logic             o_ovf
);

  logic [31:0] v;
  logic [31:0] t;
  logic        out_bit;
  logic        dbl;
  logic        left;
  logic [1:0]  kind;
  logic [4:0]  cnt;

  always_comb begin
    dbl     = i_desc[SD_DBL];
    left    = i_desc[SD_LEFT];
    kind    = i_desc[SD_TYPE_LSB +: 2];
    cnt     = i_desc[SD_CNT_LSB +: 5];
    // Single words ride in the upper half so bit 31 is always the sign
    v       = dbl ? {i_hi, i_lo} : {i_hi, 16'h0000};
    out_bit = 1'b0;
    o_ovf   = 1'b0;
    t       = v;
    for (int i = 0; i < 31; i++) begin
      if (5'(i) < cnt) begin
        if (left) begin
          out_bit = v[31];
          t       = {v[30:0], 1'b0};
          if (kind == SH_CIRC) begin
            if (dbl) begin
              t[0] = out_bit;
            end else begin
              t[16] = out_bit;
            end
          end
          if (t[31] != v[31]) begin
            o_ovf = 1'b1;
          end
        end else begin
          out_bit = dbl ? v[0] : v[16];
          t       = {(kind == SH_CIRC) ? out_bit : ((kind == SH_SIGN) & v[31]), v[31:1]};
          if (!dbl) begin
            t[15:0] = 16'h0000;
          end
        end
        v = t;
      end
    end
    o_hi          = v[31:16];
    o_lo          = v[15:0];
    o_carry       = out_bit;
    o_carry_valid = (cnt != 5'h00);
  end

endmodule : cix_shifter

`default_nettype wire
